// ==== sss_pkg.sv ====
// constants and helpers for the slave-select gated serial port
//
// Contract
// RULE1: select-pin sync only in slave mode 0100
// RULE2: select low enables shifting and drives output
// RULE3: select high releases data output at once
// RULE4: select high resets transfer state in mode 0100
// RULE5: module reset clears the bit counter
// RULE6: software picks mode 0100 for slave with edge set
// RULE7: select pin stays input, never driven low
// RULE8: data output as input suppresses transmit only
// RULE9: master transfer freezes in sleep, then resumes
// RULE10: slave shifting follows serial clock in any power mode
// RULE11: eighth slave bit sets flag and may wake
// RULE12: wake from sleep in slave, idle in both
// RULE13: system reset disables port, drops transfer
// RULE14: spi modes map onto idle level and edge
// RULE15: sample-phase bit picks the input sample point
// RULE16: buffer write loads buffer and shift register
// RULE17: status low six bits read-only, top two writable
// RULE18: mode field decodes master rates and slave modes
// RULE19: write during transfer dropped, collision flag set
// RULE20: received byte to buffer, full flag, read clears
// RULE21: select and completion pass two-flop synchroniser
package sss_pkg;
   // register byte offsets on the bus
   localparam logic [11:0] SSS_OFS_BUFFER = 12'h000;
   localparam logic [11:0] SSS_OFS_CONTROL = 12'h004;
   localparam logic [11:0] SSS_OFS_STATUS = 12'h008;
   localparam logic [11:0] SSS_OFS_AUX = 12'h00c;
   // control register fields
   localparam int SSS_CTL_COLLISION = 7;
   localparam int SSS_CTL_OVERFLOW = 6;
   localparam int SSS_CTL_ENABLE = 5;
   localparam int SSS_CTL_IDLE_LEVEL = 4;
   // status register fields
   localparam int SSS_STA_SAMPLE = 7;
   localparam int SSS_STA_EDGE = 6;
   localparam int SSS_STA_FULL = 0;
   // auxiliary register fields
   localparam int SSS_AUX_FLAG = 0;
   localparam int SSS_AUX_IRQ_EN = 1;
   localparam int SSS_AUX_SDO_IN = 2;
   // reset values
   localparam logic [7:0] SSS_RST_BYTE = 8'h00;
   localparam logic [3:0] SSS_RST_MODE = 4'h0;
   // mode field encodings
   localparam logic [3:0] SSS_MODE_MST_DIV4 = 4'h0;
   localparam logic [3:0] SSS_MODE_MST_DIV16 = 4'h1;
   localparam logic [3:0] SSS_MODE_MST_DIV64 = 4'h2;
   localparam logic [3:0] SSS_MODE_MST_TIMER = 4'h3;
   localparam logic [3:0] SSS_MODE_SLV_SEL = 4'h4;
   localparam logic [3:0] SSS_MODE_SLV_FREE = 4'h5;
   // half serial-clock periods in system clocks; mode 0010 uses 16, which gives a divide by 32
   localparam logic [4:0] SSS_HALF_DIV4 = 5'h02;
   localparam logic [4:0] SSS_HALF_DIV16 = 5'h08;
   localparam logic [4:0] SSS_HALF_DIV64 = 5'h10;
   // clock edges in one byte, bits in one byte less one
   localparam logic [4:0] SSS_EDGES = 5'h10;
   localparam logic [2:0] SSS_LAST_BIT = 3'h7;

   function automatic logic sss_is_master(input logic [3:0] mode);
      return mode <= SSS_MODE_MST_TIMER;
   endfunction : sss_is_master

   function automatic logic sss_is_slave(input logic [3:0] mode);
      return (mode == SSS_MODE_SLV_SEL) || (mode == SSS_MODE_SLV_FREE);
   endfunction : sss_is_slave
endpackage : sss_pkg

// ==== sss_serial_port.sv ====
// spi port with slave-select gating, power-mode behaviour and apb registers
`timescale 1ns/1ps
`default_nettype none
module sss_serial_port
   import sss_pkg::*;
(
   input wire logic clock,          // system clock, 10 MHz
   input wire logic rst_n,          // asynchronous system reset
   input wire logic psel,           // apb select
   input wire logic penable,        // apb access phase
   input wire logic pwrite,         // apb direction
   input wire logic [11:0] paddr,   // apb byte address
   input wire logic [31:0] pwdata,  // apb write data
   output logic [31:0] prdata,      // apb read data
   output logic pready,             // apb ready
   output logic pslverr,            // apb error on unmapped address
   input wire logic sck_i,          // serial clock pin level
   output logic sck_o,              // serial clock driven in master mode
   output logic sck_oe,             // serial clock drive enable
   input wire logic sdi,            // serial data in
   output logic sdo_o,              // serial data out
   output logic sdo_oe,             // serial data out drive enable
   input wire logic select_n,       // slave select, active low
   input wire logic timer_tick,     // timer output pulse for mode 0011
   input wire logic sleep_mode,     // device is asleep
   input wire logic idle_mode,      // device is idle
   output logic port_interrupt_flag, // sticky completion flag
   output logic wake_request        // wake the processor
);
   logic [7:0] serial_shift_buffer;
   logic [7:0] serial_shift_register;
   logic [7:0] rx_shift;
   logic [3:0] port_mode_field;
   logic port_enable_bit;
   logic clock_idle_level;
   logic clock_edge_select;
   logic sample_phase_select;
   logic write_collision_flag;
   logic receive_overflow_flag;
   logic buffer_full_flag;
   logic port_interrupt_enable;
   logic sdo_as_input;
   logic [1:0] sck_sync;
   logic [1:0] sel_sync;
   logic [1:0] sdi_sync;
   logic sck_prev;
   logic [2:0] bit_count;
   logic mst_busy;
   logic [4:0] half_cnt;
   logic [4:0] div_cnt;
   logic cap_pend;
   logic sck_level;
   logic done_pulse;
   logic [1:0] done_sync;
   logic done_seen;

   logic is_master;
   logic is_slave;
   logic mod_rst;
   logic slv_run;
   logic [4:0] half_limit;
   logic div_tick;
   logic mst_tick;
   logic lead_ev;
   logic trail_ev;
   logic out_ev;
   logic cap_ev;
   logic cap_now;
   logic shift_ok;
   logic rx_bit;
   logic in_progress;
   logic wr_en;
   logic rd_en;
   logic setup;
   logic mapped;
   logic buf_wr;
   logic buf_wr_ok;
   logic complete;
   logic done_event;

   assign is_master = port_enable_bit && sss_is_master(port_mode_field); // [RULE18]
   assign is_slave = port_enable_bit && sss_is_slave(port_mode_field); // [RULE18]
   // select high in mode 0100 or a cleared enable holds the transfer in reset
   assign mod_rst = !port_enable_bit
      || (port_mode_field == SSS_MODE_SLV_SEL && sel_sync[1]); // [RULE4] [RULE5]
   assign slv_run = is_slave
      && (port_mode_field == SSS_MODE_SLV_FREE || !sel_sync[1]); // [RULE1] [RULE2]

   // bus access decode
   assign setup = psel && !penable;
   assign mapped = (paddr == SSS_OFS_BUFFER) || (paddr == SSS_OFS_CONTROL)
      || (paddr == SSS_OFS_STATUS) || (paddr == SSS_OFS_AUX);
   assign wr_en = psel && penable && pwrite && mapped;
   assign rd_en = psel && penable && !pwrite && mapped;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign buf_wr = wr_en && (paddr == SSS_OFS_BUFFER);
   assign in_progress = is_master ? mst_busy : (bit_count != 3'h0);
   assign buf_wr_ok = buf_wr && !in_progress; // [RULE19]

   // synchronisers; the first stage feeds only the second
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sck_sync <= 2'b00;
         sel_sync <= 2'b11;
         sdi_sync <= 2'b00;
         sck_prev <= 1'b0;
      end else begin
         sck_sync <= {sck_sync[0], sck_i};
         sel_sync <= {sel_sync[0], select_n}; // [RULE21]
         sdi_sync <= {sdi_sync[0], sdi};
         sck_prev <= sck_sync[1];
      end
   end

   // master rate divider, one-cycle tick per half serial period
   always_comb begin
      case (port_mode_field)
         SSS_MODE_MST_DIV4: half_limit = SSS_HALF_DIV4;
         SSS_MODE_MST_DIV16: half_limit = SSS_HALF_DIV16;
         SSS_MODE_MST_DIV64: half_limit = SSS_HALF_DIV64;
         default: half_limit = SSS_HALF_DIV4;
      endcase
   end

   assign div_tick = (port_mode_field == SSS_MODE_MST_TIMER) ? timer_tick
      : (div_cnt == half_limit - 5'h01); // [RULE18]

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= 5'h00;
      end else if (!mst_busy || sleep_mode || div_tick) begin
         div_cnt <= 5'h00; // [RULE9]
      end else begin
         div_cnt <= div_cnt + 5'h01;
      end
   end

   // all master clocks stop while asleep; the transfer resumes on return
   assign mst_tick = is_master && mst_busy && !sleep_mode && div_tick; // [RULE9]

   // leading edge leaves the idle level, trailing edge returns to it
   always_comb begin
      if (is_master) begin
         lead_ev = mst_tick && (half_cnt < SSS_EDGES) && !half_cnt[0];
         trail_ev = mst_tick && (half_cnt < SSS_EDGES) && half_cnt[0];
      end else begin
         lead_ev = slv_run && (sck_sync[1] != sck_prev)
            && (sck_sync[1] != clock_idle_level); // [RULE10]
         trail_ev = slv_run && (sck_sync[1] != sck_prev)
            && (sck_sync[1] == clock_idle_level); // [RULE10]
      end
   end

   // edge set: output changes on trailing edge, captured on leading
   assign out_ev = clock_edge_select ? trail_ev : lead_ev; // [RULE14]
   assign cap_ev = clock_edge_select ? lead_ev : trail_ev; // [RULE14]
   // master may move the sample to the end of the bit time
   assign cap_now = (is_master && sample_phase_select)
      ? (mst_tick && cap_pend) : cap_ev; // [RULE15]
   // the first bit is already on the pin; no shift on the very first edge
   assign shift_ok = is_master
      ? !(!clock_edge_select && half_cnt == 5'h00) : (bit_count != 3'h0);
   assign rx_bit = sdi_sync[1];
   assign complete = cap_now && (bit_count == SSS_LAST_BIT);

   // master sequencer
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mst_busy <= 1'b0; // [RULE13]
         half_cnt <= 5'h00;
         cap_pend <= 1'b0;
         sck_level <= 1'b0;
      end else if (!is_master) begin
         mst_busy <= 1'b0;
         half_cnt <= 5'h00;
         cap_pend <= 1'b0;
         sck_level <= clock_idle_level; // [RULE14]
      end else if (buf_wr_ok) begin
         mst_busy <= 1'b1; // [RULE16]
         half_cnt <= 5'h00;
         cap_pend <= 1'b0;
         sck_level <= clock_idle_level;
      end else if (mst_tick) begin
         cap_pend <= cap_ev;
         if (half_cnt < SSS_EDGES) begin
            sck_level <= !sck_level;
            half_cnt <= half_cnt + 5'h01;
         end else begin
            mst_busy <= 1'b0;
         end
      end else if (!mst_busy) begin
         sck_level <= clock_idle_level;
      end
   end

   // bit counter, cleared by any module reset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bit_count <= 3'h0; // [RULE13]
      end else if (mod_rst || (is_master && buf_wr_ok)) begin
         bit_count <= 3'h0; // [RULE5]
      end else if (cap_now) begin
         bit_count <= bit_count + 3'h1;
      end
   end

   // transmit shifter is loaded together with the buffer
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         serial_shift_register <= SSS_RST_BYTE;
      end else if (buf_wr_ok) begin
         serial_shift_register <= pwdata[7:0]; // [RULE16]
      end else if (out_ev && shift_ok) begin
         serial_shift_register <= {serial_shift_register[6:0], 1'b0}; // [RULE2]
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_shift <= SSS_RST_BYTE;
      end else if (cap_now) begin
         rx_shift <= {rx_shift[6:0], rx_bit}; // [RULE8]
      end
   end

   // completion passes a toggle through two flops before the flags see it
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         done_pulse <= 1'b0;
         done_sync <= 2'b00;
         done_seen <= 1'b0;
      end else begin
         if (complete) begin
            done_pulse <= !done_pulse;
         end
         done_sync <= {done_sync[0], done_pulse}; // [RULE21]
         done_seen <= done_sync[1];
      end
   end
   assign done_event = (done_sync[1] != done_seen) && port_enable_bit;

   // receive buffer; a buffer write also replaces its content
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         serial_shift_buffer <= SSS_RST_BYTE;
      end else if (buf_wr_ok) begin
         serial_shift_buffer <= pwdata[7:0]; // [RULE16]
      end else if (complete) begin
         serial_shift_buffer <= {rx_shift[6:0], rx_bit}; // [RULE20]
      end
   end

   // buffer full: set by a completed byte, cleared by a buffer read
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         buffer_full_flag <= 1'b0;
      end else if (!port_enable_bit) begin
         buffer_full_flag <= 1'b0;
      end else if (done_event) begin
         buffer_full_flag <= 1'b1; // [RULE20]
      end else if (rd_en && paddr == SSS_OFS_BUFFER) begin
         buffer_full_flag <= 1'b0; // [RULE20]
      end
   end

   // control register with hardware-set flags; a set beats a write
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         write_collision_flag <= 1'b0;
         receive_overflow_flag <= 1'b0;
         port_enable_bit <= 1'b0; // [RULE13]
         clock_idle_level <= 1'b0;
         port_mode_field <= SSS_RST_MODE;
      end else begin
         if (wr_en && paddr == SSS_OFS_CONTROL) begin
            port_enable_bit <= pwdata[SSS_CTL_ENABLE];
            clock_idle_level <= pwdata[SSS_CTL_IDLE_LEVEL];
            port_mode_field <= pwdata[3:0];
         end
         if (buf_wr && in_progress) begin
            write_collision_flag <= 1'b1; // [RULE19]
         end else if (wr_en && paddr == SSS_OFS_CONTROL) begin
            write_collision_flag <= pwdata[SSS_CTL_COLLISION];
         end
         if (done_event && is_slave && buffer_full_flag) begin
            receive_overflow_flag <= 1'b1;
         end else if (wr_en && paddr == SSS_OFS_CONTROL) begin
            receive_overflow_flag <= pwdata[SSS_CTL_OVERFLOW];
         end
      end
   end

   // status top two bits are the only writable ones
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sample_phase_select <= 1'b0;
         clock_edge_select <= 1'b0;
      end else if (wr_en && paddr == SSS_OFS_STATUS) begin
         sample_phase_select <= pwdata[SSS_STA_SAMPLE]; // [RULE17]
         clock_edge_select <= pwdata[SSS_STA_EDGE]; // [RULE17]
      end
   end

   // interrupt flag, enable and data-out direction
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         port_interrupt_flag <= 1'b0;
         port_interrupt_enable <= 1'b0;
         sdo_as_input <= 1'b0;
      end else begin
         if (wr_en && paddr == SSS_OFS_AUX) begin
            port_interrupt_enable <= pwdata[SSS_AUX_IRQ_EN];
            sdo_as_input <= pwdata[SSS_AUX_SDO_IN];
         end
         if (done_event) begin
            port_interrupt_flag <= 1'b1; // [RULE11]
         end else if (wr_en && paddr == SSS_OFS_AUX) begin
            port_interrupt_flag <= pwdata[SSS_AUX_FLAG];
         end
      end
   end

   // read data captured in the setup phase, held through access
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         case (paddr)
            SSS_OFS_BUFFER: prdata <= {24'h00_0000, serial_shift_buffer};
            SSS_OFS_CONTROL: prdata <= {24'h00_0000, write_collision_flag,
               receive_overflow_flag, port_enable_bit, clock_idle_level,
               port_mode_field};
            SSS_OFS_STATUS: prdata <= {24'h00_0000, sample_phase_select,
               clock_edge_select, 5'h00, buffer_full_flag}; // [RULE17]
            SSS_OFS_AUX: prdata <= {29'h0000_0000, sdo_as_input,
               port_interrupt_enable, port_interrupt_flag};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // pins: select high releases data out at once, without synchroniser delay
   assign sdo_o = serial_shift_register[7];
   assign sdo_oe = !sdo_as_input && (is_master || (is_slave
      && (port_mode_field == SSS_MODE_SLV_FREE || !select_n))); // [RULE3] [RULE8]
   assign sck_o = sck_level;
   assign sck_oe = is_master;

   // wake from sleep only as slave, from idle in either mode
   assign wake_request = port_interrupt_enable && port_interrupt_flag
      && ((sleep_mode && is_slave) || (idle_mode && !sleep_mode)); // [RULE11] [RULE12]
endmodule : sss_serial_port
`default_nettype wire

// ==== sss_serial_port_asserts.sv ====
// assertions on the serial port pins, interrupt flag and wake request
`timescale 1ns/1ps
`default_nettype none
module sss_serial_port_asserts
   import sss_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic rst_n, // reset
   input wire logic psel, // apb
   input wire logic penable, // apb
   input wire logic pwrite, // apb
   input wire logic [11:0] paddr, // apb
   input wire logic [31:0] pwdata, // apb
   input wire logic sck_o, // clock out
   input wire logic sck_oe, // clock drive
   input wire logic sdo_oe, // data drive
   input wire logic select_n, // select
   input wire logic sleep_mode, // asleep
   input wire logic idle_mode, // idle
   input wire logic port_interrupt_flag, // flag
   input wire logic wake_request // wake
);
   logic [7:0] ctl;
   logic [1:0] aux;
   logic on;
   logic sel;
   logic wk;
   assign on = ctl[SSS_CTL_ENABLE];
   assign sel = on && ctl[3:0] == SSS_MODE_SLV_SEL;
   assign wk = aux[0] && port_interrupt_flag && ((sleep_mode && on && sss_is_slave(ctl[3:0]))
      || (idle_mode && !sleep_mode));
   // shadow of the configuration written over the bus
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctl <= 8'h00;
         aux <= 2'h0;
      end else if (psel && penable && pwrite) begin
         if (paddr == SSS_OFS_CONTROL) ctl <= pwdata[7:0];
         if (paddr == SSS_OFS_AUX) aux <= pwdata[2:1];
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   sel_release_a: assert property (sel && select_n |-> !sdo_oe)
      else $error("data out driven while deselected");
   sel_drive_a: assert property (sel && !select_n && !aux[1] |-> sdo_oe)
      else $error("data out not driven while selected");
   free_drive_a: assert property (on && ctl[3:0] == SSS_MODE_SLV_FREE && !aux[1] |-> sdo_oe)
      else $error("free slave not driving data out");
   rx_only_a: assert property (aux[1] |-> !sdo_oe)
      else $error("data out driven while set as input");
   master_clk_a: assert property (sck_oe == (on && sss_is_master(ctl[3:0])))
      else $error("clock drive does not follow mode");
   sleep_hold_a: assert property (sck_oe && sleep_mode && $past(sleep_mode) |-> $stable(sck_o))
      else $error("master clock moved during sleep");
   wake_map_a: assert property (wake_request == wk)
      else $error("wake request wrong for power state");
   wake_flag_a: assert property (wake_request |-> port_interrupt_flag)
      else $error("wake without flag");
   reset_off_a: assert property ($rose(rst_n) |-> !sck_oe && !port_interrupt_flag)
      else $error("port active after reset");
   cover property ($rose(port_interrupt_flag));
   cover property ($rose(wake_request));
   cover property (sck_oe && sleep_mode && $past(sleep_mode));
endmodule : sss_serial_port_asserts
bind sss_serial_port sss_serial_port_asserts i_chk (.clock, .rst_n, .psel, .penable, .pwrite,
   .paddr, .pwdata, .sck_o, .sck_oe, .sdo_oe, .select_n, .sleep_mode, .idle_mode,
   .port_interrupt_flag, .wake_request);
`default_nettype wire

// ==== sss_spi_master_model.sv ====
// behavioural spi master driving the port's slave pins
`timescale 1ns/1ps
`default_nettype none
module sss_spi_master_model (
   input wire logic clock, // paces the link
   output logic sck, // serial clock
   output logic sdi, // data to port
   output logic select_n, // select, active low
   input wire logic sdo_o, // port data out
   input wire logic sdo_oe // port drives data
);
   logic cpol;
   logic cke;
   logic [7:0] rx_q;
   logic drv_q;
   initial begin
      sck = 1'b0;
      sdi = 1'b0;
      select_n = 1'b1;
      cpol = 1'b0;
      cke = 1'b1;
   end
   task automatic half();
      repeat (5) @(posedge clock);
   endtask : half
   task automatic grab();
      // a released data line reads back as the inverse of the port's present sdo_o
      rx_q = {rx_q[6:0], sdo_oe ? sdo_o : ~sdo_o};
      drv_q = drv_q | sdo_oe;
   endtask : grab
   task automatic set_mode(input logic p, input logic e);
      cpol = p;
      cke = e;
      sck <= p;
   endtask : set_mode
   task automatic xfer(input int nbits, input logic [7:0] tx, output logic [7:0] rx,
      output logic drv);
      rx_q = 8'h00;
      drv_q = 1'b0;
      select_n <= 1'b0;
      half();
      for (int i = 0; i < nbits; i++) begin
         if (cke) sdi <= tx[7 - i];
         half();
         sck <= ~cpol;
         if (cke) grab();
         else sdi <= tx[7 - i];
         half();
         sck <= cpol;
         if (!cke) grab();
      end
      half();
      select_n <= 1'b1;
      sdi <= ~sdi;
      rx = rx_q;
      drv = drv_q;
   endtask : xfer
endmodule : sss_spi_master_model
`default_nettype wire

// ==== sss_serial_port_tb_top.sv ====
// self-checking bench for the slave-select gated serial port
`timescale 1ns/1ps
`default_nettype none
module sss_serial_port_tb_top import sss_pkg::*;;
   logic clock, rst_n, psel, penable, pwrite, pready, pslverr, err, drv, s;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic sck_i, m_sck, sck_o, sck_oe, sdi, sdo_o, sdo_oe, select_n;
   logic timer_tick, sleep_mode, idle_mode, port_interrupt_flag, wake_request;
   logic [7:0] got;
   int n_mismatch, n_compared;
   assign sck_i = sck_oe ? sck_o : m_sck;
   sss_serial_port i_dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .sck_i, .sck_o, .sck_oe, .sdi, .sdo_o, .sdo_oe, .select_n,
      .timer_tick, .sleep_mode, .idle_mode, .port_interrupt_flag, .wake_request);
   sss_spi_master_model i_mst (.clock, .sck(m_sck), .sdi, .select_n, .sdo_o, .sdo_oe);
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task automatic print_verdict();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge clock);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 16) check(1'b0, 1'b1);
      if (n == 16) print_verdict();
   endtask : apb
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rdchk
   task automatic wait_flag();
      int n;
      for (n = 0; n < 64; n++) begin
         if (port_interrupt_flag === 1'b1) break;
         @(posedge clock);
      end
      check(port_interrupt_flag, 1'b1);
      if (n == 64) print_verdict();
   endtask : wait_flag
   task automatic t_reset();
      rdchk(SSS_OFS_CONTROL, 32'h0);
      rdchk(SSS_OFS_AUX, 32'h0);
      apb(1'b1, SSS_OFS_STATUS, 32'hff);
      rdchk(SSS_OFS_STATUS, 32'hc0);
      apb(1'b1, SSS_OFS_STATUS, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      check(err, 1'b1);
   endtask : t_reset
   task automatic t_modes();
      logic [7:0] tx;
      logic [7:0] rx;
      for (int i = 0; i < 4; i++) begin
         tx = 8'h96 + 8'(i);
         rx = 8'h3c ^ 8'(i);
         apb(1'b1, SSS_OFS_CONTROL, 32'h0);
         i_mst.set_mode(i[1], ~i[0]);
         apb(1'b1, SSS_OFS_STATUS, {25'h0, ~i[0], 6'h0});
         apb(1'b1, SSS_OFS_CONTROL, {27'h1, i[1], 4'h4});
         apb(1'b1, SSS_OFS_BUFFER, {24'h0, tx});
         sleep_mode <= 1'b1;
         i_mst.xfer(8, rx, got, drv);
         sleep_mode <= 1'b0;
         wait_flag();
         check(drv, 1'b1);
         check(got, tx);
         rdchk(SSS_OFS_STATUS, {25'h0, ~i[0], 6'h1});
         rdchk(SSS_OFS_BUFFER, rx);
         rdchk(SSS_OFS_STATUS, {25'h0, ~i[0], 6'h0});
         apb(1'b1, SSS_OFS_AUX, 32'h0);
      end
   endtask : t_modes
   task automatic t_abort();
      apb(1'b1, SSS_OFS_CONTROL, 32'h0);
      i_mst.set_mode(1'b0, 1'b1);
      apb(1'b1, SSS_OFS_STATUS, 32'h40);
      apb(1'b1, SSS_OFS_CONTROL, 32'h24);
      i_mst.xfer(3, 8'hff, got, drv);
      @(posedge clock);
      check(sdo_oe, 1'b0);
      check(port_interrupt_flag, 1'b0);
      // the free slave mode is only legal with the edge bit clear
      apb(1'b1, SSS_OFS_STATUS, 32'h0);
      i_mst.set_mode(1'b0, 1'b0);
      apb(1'b1, SSS_OFS_CONTROL, 32'h25);
      i_mst.xfer(3, 8'hff, got, drv);
      apb(1'b1, SSS_OFS_CONTROL, 32'h05);
      i_mst.set_mode(1'b0, 1'b1);
      apb(1'b1, SSS_OFS_STATUS, 32'h40);
      apb(1'b1, SSS_OFS_CONTROL, 32'h24);
      i_mst.xfer(8, 8'h5a, got, drv);
      wait_flag();
      rdchk(SSS_OFS_BUFFER, 32'h5a);
      apb(1'b1, SSS_OFS_AUX, 32'h04);
      i_mst.xfer(8, 8'hc3, got, drv);
      wait_flag();
      check(drv, 1'b0);
      rdchk(SSS_OFS_BUFFER, 32'hc3);
   endtask : t_abort
   task automatic t_wake();
      apb(1'b1, SSS_OFS_AUX, 32'h03);
      sleep_mode <= 1'b1;
      repeat (2) @(posedge clock);
      check(wake_request, 1'b1);
      apb(1'b1, SSS_OFS_CONTROL, 32'h20);
      @(posedge clock);
      check(wake_request, 1'b0);
      sleep_mode <= 1'b0;
      idle_mode <= 1'b1;
      repeat (2) @(posedge clock);
      check(wake_request, 1'b1);
      idle_mode <= 1'b0;
      apb(1'b1, SSS_OFS_AUX, 32'h0);
   endtask : t_wake
   task automatic t_decode();
      apb(1'b1, SSS_OFS_STATUS, 32'h0);
      for (int m = 0; m < 6; m++) begin
         apb(1'b1, SSS_OFS_CONTROL, 32'h20 | m);
         @(posedge clock);
         check(sck_oe, m < 4);
         check(sdo_oe, m != 4);
      end
   endtask : t_decode
   task automatic t_master();
      apb(1'b1, SSS_OFS_CONTROL, 32'h20);
      apb(1'b1, SSS_OFS_BUFFER, 32'h55);
      apb(1'b1, SSS_OFS_BUFFER, 32'h66);
      rdchk(SSS_OFS_CONTROL, 32'ha0);
      sleep_mode <= 1'b1;
      repeat (2) @(posedge clock);
      s = sck_o;
      repeat (20) @(posedge clock);
      check(sck_o, s);
      check(port_interrupt_flag, 1'b0);
      sleep_mode <= 1'b0;
      wait_flag();
      // system reset just as a master byte starts
      apb(1'b1, SSS_OFS_BUFFER, 32'h5a);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      check(sck_oe, 1'b0);
      rdchk(SSS_OFS_CONTROL, 32'h0);
      repeat (40) @(posedge clock);
      check(port_interrupt_flag, 1'b0);
   endtask : t_master
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      timer_tick = 1'b0;
      sleep_mode = 1'b0;
      idle_mode = 1'b0;
      n_mismatch = 0;
      n_compared = 0;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      t_reset();
      t_modes();
      t_abort();
      t_wake();
      t_decode();
      t_master();
      print_verdict();
   end
endmodule : sss_serial_port_tb_top
`default_nettype wire
